// ===== design/itpp_top.sv
// Operation
// R01: The test control, test window and promotion registers sit at indices 0x15, 0x16 and 0x1F from a relocatable base.
// R02: The test write enable bit 4 reads anytime and is written only in special mode with both I and X masks set.
// R03: With test write enable clear, window writes are blocked and window reads show the live request inputs.
// R04: With test write enable set, the decoder sees the stored test bits instead of the request inputs.
// R05: Requests pending when test write enable is set stay pending until software overwrites them.
// R06: The group select field in bits 3:0 reads and writes anytime and equals the upper nibble of the vector low byte.
// R07: There is one eight bit test register per eight vectors, all at one address, chosen by the group select.
// R08: Window reads work only in special mode, showing live inputs or stored bits, and read zero in normal mode.
// R09: Window writes take effect only in special mode with test write enable set and the I mask set.
// R10: Test bit 7 maps to low nibble E of the group and bit 0 to low nibble 0, in steps of two.
// R11: With group select F only bits 2:0 are reachable and bits 7:3 read as zero.
// R12: A group select that names an unimplemented register discards writes and reads zero.
// R13: The promotion register reads anytime and is written only while the I mask is set.
// R14: Software writes a vector low byte into bits 7:1 and that source becomes the top I-bit priority.
// R15: An unimplemented vector or a value above 0xF2 makes the 0xF2 request the top I-bit source.
// R16: When the promoted source is active, its vector is passed to the decoder ahead of other I-bit requests.
// R17: Test control bits above bit 4 and promotion bit 0 read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module itpp_top (
	input  wire logic                         CLK,
	input  wire logic                         RESET,
	input  wire logic                         PSEL,
	input  wire logic                         PENABLE,
	input  wire logic                         PWRITE,
	input  wire logic [7:0]                   PADDR,
	input  wire logic [31:0]                  PWDATA,
	output logic      [31:0]                  PRDATA,
	output logic                              PREADY,
	output logic                              PSLVERR,
	input  wire logic                         SPECIAL_MODE,
	input  wire logic                         I_MASK,
	input  wire logic                         X_MASK,
	input  wire logic [itpp_pkg::REQ_WIDTH-1:0] INT_REQ,
	output logic      [itpp_pkg::REQ_WIDTH-1:0] DEC_REQ,
	output logic                              PROMO_ACTIVE,
	output logic      [7:0]                   PROMO_VEC
);

	itpp_pkg::itpp_test_ctrl_s          ctrl;
	logic [itpp_pkg::REQ_WIDTH-1:0]     test_bits;
	logic [7:0]                         promo_sel;

	// Address decode; unmapped or misaligned addresses answer with an error.
	itpp_pkg::itpp_decode_s dec;
	assign dec.sel_ctrl   = (PADDR == itpp_pkg::ADDR_TEST_CTRL);   // see R01
	assign dec.sel_window = (PADDR == itpp_pkg::ADDR_TEST_WINDOW); // see R01
	assign dec.sel_promo  = (PADDR == itpp_pkg::ADDR_PROMO_SEL);   // see R01
	assign dec.mapped     = dec.sel_ctrl | dec.sel_window | dec.sel_promo;

	// A write lands only at the access edge that also sees PREADY high.
	wire wr_go    = PSEL & PENABLE & PWRITE & PREADY;
	wire wr_ctrl  = wr_go & dec.sel_ctrl;
	wire wr_win   = wr_go & dec.sel_window;
	wire wr_promo = wr_go & dec.sel_promo;
	wire setup    = PSEL & ~PENABLE;

	// Window group slice; bit k of a group is the vector with low nibble 2k.
	wire [6:0] grp_base  = {ctrl.group_select, 3'b000};           // see R10
	wire       grp_impl  = itpp_pkg::IMPL_GROUPS[ctrl.group_select]; // see R12
	wire [7:0] grp_mask  = (ctrl.group_select == itpp_pkg::TOP_GROUP) ?
		itpp_pkg::TOP_GROUP_MASK : itpp_pkg::FULL_MASK;          // see R11
	wire [7:0] live_grp  = INT_REQ[grp_base +: itpp_pkg::GROUP_WIDTH];
	wire [7:0] test_grp  = test_bits[grp_base +: itpp_pkg::GROUP_WIDTH];
	wire [7:0] shown_grp = ctrl.test_write_enable ? test_grp : live_grp;
	wire [7:0] win_rd    = (SPECIAL_MODE & grp_impl) ?
		(shown_grp & grp_mask) : 8'h00;                          // see R08

	// Enable bit guard: special mode and both masks.
	wire wrt_allowed = SPECIAL_MODE & I_MASK & X_MASK;          // see R02
	wire next_test_write_enable = (wr_ctrl & wrt_allowed) ?
		PWDATA[itpp_pkg::TEST_WRITE_ENABLE_BIT] : ctrl.test_write_enable;
	wire test_write_enable_rise = next_test_write_enable & ~ctrl.test_write_enable;

	// Window write guard; the I mask alone suffices here.
	wire win_allowed = SPECIAL_MODE & ctrl.test_write_enable & I_MASK &
		grp_impl;                                                // see R09
	wire [7:0] next_grp = (test_grp & ~grp_mask) |
		(PWDATA[7:0] & grp_mask);                                // see R11

	// Read data mux; unused bits read as zero.
	wire [7:0] ctrl_rd = {3'b000, ctrl.test_write_enable,
		ctrl.group_select};                                      // see R17
	wire [7:0] promo_rd = {promo_sel[7:1], 1'b0};                // see R17
	wire [7:0] rd_byte = dec.sel_ctrl ? ctrl_rd :
		dec.sel_window ? win_rd :
		dec.sel_promo ? promo_rd : 8'h00;

	// Promotion target: fall back to the 0xF2 source when out of range.
	wire       promo_ok  = (promo_sel <= itpp_pkg::PROMO_MAX) &
		itpp_pkg::IMPL_GROUPS[promo_sel[7:4]];                   // see R15
	wire [7:0] promo_eff = promo_ok ? {promo_sel[7:1], 1'b0} :
		itpp_pkg::PROMO_DEFAULT;                                 // see R15

	// Decoder feed: stored bits replace the inputs while testing.
	wire [itpp_pkg::REQ_WIDTH-1:0] next_dec = ctrl.test_write_enable ?
		test_bits : INT_REQ;                                     // see R04

	// Bus answer: one setup cycle, then PREADY high in the access cycle.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end else begin
			PREADY  <= setup;                                    // see R01
			PSLVERR <= setup & ~dec.mapped;
			PRDATA  <= (setup & ~PWRITE) ? {24'h000000, rd_byte} :
				32'h00000000;
		end
	end

	// Test control: group select always writable, enable bit guarded.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ctrl.test_write_enable <= itpp_pkg::RESET_TEST_WRITE;
			ctrl.group_select      <= itpp_pkg::RESET_GROUP_SELECT;
		end else begin
			ctrl.test_write_enable <= next_test_write_enable;               // see R02
			if (wr_ctrl) begin
				ctrl.group_select <= PWDATA[itpp_pkg::GROUP_SELECT_MSB:0]; // see R06
			end
		end
	end

	// Test bits. When the enable rises, live requests are captured so that
	// nothing pending is lost the moment the inputs are cut off.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			test_bits <= '0;
		end else if (test_write_enable_rise) begin
			test_bits <= INT_REQ;                                // see R05
		end else if (wr_win & win_allowed) begin
			test_bits[grp_base +: itpp_pkg::GROUP_WIDTH] <= next_grp; // see R07
		end
	end

	// Promotion select; only bits 7:1 are stored.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			promo_sel <= itpp_pkg::RESET_PROMO_SEL;
		end else if (wr_promo & I_MASK) begin
			promo_sel <= {PWDATA[7:1], 1'b0};                    // see R13
		end
	end

	// Decoder outputs. The promoted vector and its activity are registered
	// alongside the request vector so the decoder sees a coherent set.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			DEC_REQ      <= '0;
			PROMO_ACTIVE <= 1'b0;
			PROMO_VEC    <= itpp_pkg::PROMO_DEFAULT;
		end else begin
			DEC_REQ      <= next_dec;
			PROMO_ACTIVE <= next_dec[promo_eff[7:1]];            // see R16
			PROMO_VEC    <= promo_eff;                           // see R14
		end
	end

	// Checks.
	property p_test_write_enable_guard;
		@(posedge CLK) disable iff (RESET)
		(wr_ctrl & ~(SPECIAL_MODE & I_MASK & X_MASK)) |=>
			$stable(ctrl.test_write_enable);
	endproperty
	a_test_write_enable_guard: assert property (p_test_write_enable_guard) // see R02
		else $error("Enable bit changed without permission.");

	property p_group_write;
		@(posedge CLK) disable iff (RESET)
		wr_ctrl |=> ctrl.group_select == $past(PWDATA[3:0]);
	endproperty
	a_group_write: assert property (p_group_write) // see R06
		else $error("Group select did not take the written value.");

	property p_window_block;
		@(posedge CLK) disable iff (RESET)
		(wr_win & ~ctrl.test_write_enable & ~test_write_enable_rise) |=>
			$stable(test_bits);
	endproperty
	a_window_block: assert property (p_window_block) // see R03
		else $error("Window write landed with enable clear.");

	property p_normal_read_zero;
		@(posedge CLK) disable iff (RESET)
		(setup & ~PWRITE & dec.sel_window & ~SPECIAL_MODE) |=>
			(PRDATA == 32'h00000000) && PREADY;
	endproperty
	a_normal_read_zero: assert property (p_normal_read_zero) // see R08
		else $error("Window read not zero in normal mode.");

	property p_feed;
		@(posedge CLK) disable iff (RESET)
		##1 DEC_REQ == ($past(ctrl.test_write_enable) ?
			$past(test_bits) : $past(INT_REQ));
	endproperty
	a_feed: assert property (p_feed) // see R04
		else $error("Decoder feed took the wrong source.");

	property p_capture;
		@(posedge CLK) disable iff (RESET)
		$rose(ctrl.test_write_enable) |-> test_bits == $past(INT_REQ);
	endproperty
	a_capture: assert property (p_capture) // see R05
		else $error("Pending requests lost when enable was set.");

	property p_top_group;
		@(posedge CLK) disable iff (RESET)
		(setup & ~PWRITE & dec.sel_window &
			ctrl.group_select == itpp_pkg::TOP_GROUP) |=>
			PRDATA[7:3] == 5'h00;
	endproperty
	a_top_group: assert property (p_top_group) // see R11
		else $error("Top group upper bits read nonzero.");

	property p_promo_guard;
		@(posedge CLK) disable iff (RESET)
		(wr_promo & ~I_MASK) |=> $stable(promo_sel);
	endproperty
	a_promo_guard: assert property (p_promo_guard) // see R13
		else $error("Promotion written with I mask clear.");

	property p_promo_default;
		@(posedge CLK) disable iff (RESET)
		(promo_sel > itpp_pkg::PROMO_MAX) |=>
			PROMO_VEC == itpp_pkg::PROMO_DEFAULT;
	endproperty
	a_promo_default: assert property (p_promo_default) // see R15
		else $error("Out of range promotion did not fall back.");

	property p_ready;
		@(posedge CLK) disable iff (RESET)
		setup |=> PREADY ##1 ~PREADY;
	endproperty
	a_ready: assert property (p_ready) // see R01
		else $error("Bus answer not one cycle after setup.");

	// Unused control bits must never leak onto the read bus.
	property p_ctrl_read;
		@(posedge CLK) disable iff (RESET)
		(setup & ~PWRITE & dec.sel_ctrl) |=> PRDATA[7:5] == 3'b000;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) // see R17
		else $error("Control upper bits read nonzero.");

	property p_promo_read_bit0;
		@(posedge CLK) disable iff (RESET)
		(setup & ~PWRITE & dec.sel_promo) |=> PRDATA[0] == 1'b0;
	endproperty
	a_promo_read_bit0: assert property (p_promo_read_bit0) // see R17
		else $error("Promotion bit 0 read nonzero.");

	property p_promo_write;
		@(posedge CLK) disable iff (RESET)
		(wr_promo & I_MASK) |=> promo_sel == {$past(PWDATA[7:1]), 1'b0};
	endproperty
	a_promo_write: assert property (p_promo_write) // see R14
		else $error("Promotion select did not take the written value.");

	// Unmapped addresses answer with an error and no data.
	property p_unmapped_err;
		@(posedge CLK) disable iff (RESET)
		(setup & ~dec.mapped) |=> PSLVERR && (PRDATA == 32'h00000000);
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) // see R01
		else $error("Unmapped access without error answer.");

	property p_slverr_mapped;
		@(posedge CLK) disable iff (RESET)
		(setup & dec.mapped) |=> ~PSLVERR;
	endproperty
	a_slverr_mapped: assert property (p_slverr_mapped) // see R01
		else $error("Mapped access answered with an error.");

	property p_write_no_data;
		@(posedge CLK) disable iff (RESET)
		(setup & PWRITE) |=> PRDATA == 32'h00000000;
	endproperty
	a_write_no_data: assert property (p_write_no_data) // see R01
		else $error("Read data driven during a write.");

	// The top group is excluded since its upper bits are masked.
	property p_window_live;
		@(posedge CLK) disable iff (RESET)
		(setup & ~PWRITE & dec.sel_window & SPECIAL_MODE &
			~ctrl.test_write_enable &
			(ctrl.group_select != itpp_pkg::TOP_GROUP)) |=>
			PRDATA[7:0] == $past(live_grp);
	endproperty
	a_window_live: assert property (p_window_live) // see R03
		else $error("Window read did not show live inputs.");

	property p_window_write;
		@(posedge CLK) disable iff (RESET)
		(wr_win & win_allowed & ~test_write_enable_rise) |=>
			(test_grp & grp_mask) == ($past(PWDATA[7:0]) & grp_mask);
	endproperty
	a_window_write: assert property (p_window_write) // see R09
		else $error("Permitted window write did not land.");

	// Registers move only when their own address is written.
	property p_enable_hold;
		@(posedge CLK) disable iff (RESET)
		~wr_ctrl |=> $stable(ctrl.test_write_enable);
	endproperty
	a_enable_hold: assert property (p_enable_hold) // see R02
		else $error("Enable bit changed without a write.");

	property p_sel_hold;
		@(posedge CLK) disable iff (RESET)
		~wr_ctrl |=> $stable(ctrl.group_select);
	endproperty
	a_sel_hold: assert property (p_sel_hold) // see R06
		else $error("Group select changed without a write.");

	property p_promo_hold;
		@(posedge CLK) disable iff (RESET)
		~wr_promo |=> $stable(promo_sel);
	endproperty
	a_promo_hold: assert property (p_promo_hold) // see R13
		else $error("Promotion select changed without a write.");

	// Activity flag and vector are registered together, so they agree.
	property p_promo_active;
		@(posedge CLK) disable iff (RESET)
		PROMO_ACTIVE |-> DEC_REQ[PROMO_VEC[7:1]];
	endproperty
	a_promo_active: assert property (p_promo_active) // see R16
		else $error("Promoted source flagged active while idle.");

	property p_promo_vec_range;
		@(posedge CLK) disable iff (RESET)
		1'b1 |-> (PROMO_VEC <= itpp_pkg::PROMO_MAX) && !PROMO_VEC[0];
	endproperty
	a_promo_vec_range: assert property (p_promo_vec_range) // see R15
		else $error("Promoted vector outside the I-bit range.");

endmodule : itpp_top

`default_nettype wire

// ===== design/itpp_pkg.sv
// Shared constants and carriers for the interrupt test and promotion block.
package itpp_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_TEST_CTRL   = 8'h15;
	localparam logic [7:0] IDX_TEST_WINDOW = 8'h16;
	localparam logic [7:0] IDX_PROMO_SEL   = 8'h1F;
	localparam logic [7:0] ADDR_TEST_CTRL   = {IDX_TEST_CTRL[5:0], 2'b00};
	localparam logic [7:0] ADDR_TEST_WINDOW = {IDX_TEST_WINDOW[5:0], 2'b00};
	localparam logic [7:0] ADDR_PROMO_SEL   = {IDX_PROMO_SEL[5:0], 2'b00};

	// Field positions in the test control register.
	localparam int unsigned TEST_WRITE_ENABLE_BIT = 4;
	localparam int unsigned GROUP_SELECT_MSB      = 3;

	// Request lines: one per even vector low byte, eight per group.
	localparam int unsigned GROUP_COUNT = 16;
	localparam int unsigned GROUP_WIDTH = 8;
	localparam int unsigned REQ_WIDTH   = GROUP_COUNT * GROUP_WIDTH;

	// Groups that carry a test register; one bit per group select value.
	localparam logic [15:0] IMPL_GROUPS = 16'hFFFF;

	// The top group reaches only the three lowest vectors.
	localparam logic [3:0] TOP_GROUP      = 4'hF;
	localparam logic [7:0] TOP_GROUP_MASK = 8'h07;
	localparam logic [7:0] FULL_MASK      = 8'hFF;

	// Promotion: highest legal low byte and the fallback source.
	localparam logic [7:0] PROMO_MAX     = 8'hF2;
	localparam logic [7:0] PROMO_DEFAULT = 8'hF2;

	// Values after reset.
	localparam logic [3:0] RESET_GROUP_SELECT = 4'h0;
	localparam logic       RESET_TEST_WRITE   = 1'b0;
	localparam logic [7:0] RESET_PROMO_SEL    = PROMO_DEFAULT;

	// Test control fields as stored.
	typedef struct packed {
		logic       test_write_enable;
		logic [3:0] group_select;
	} itpp_test_ctrl_s;

	// One decoded bus access.
	typedef struct packed {
		logic sel_ctrl;
		logic sel_window;
		logic sel_promo;
		logic mapped;
	} itpp_decode_s;

endpackage : itpp_pkg

// ===== verification/itpp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core side: APB master plus the mode and mask levels that it owns.
module itpp_cpu_model (
	input  wire logic        CLK,
	input  wire logic        PREADY,
	output logic             PSEL,
	output logic             PENABLE,
	output logic             PWRITE,
	output logic [7:0]       PADDR,
	output logic [31:0]      PWDATA,
	output logic             SPECIAL_MODE,
	output logic             I_MASK,
	output logic             X_MASK
);
	// Idle bus, normal mode and clear masks at time zero.
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		{SPECIAL_MODE, I_MASK, X_MASK} = 3'b000;
	end
	// Held until PREADY is seen; released lines show junk, not old values.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge CLK);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= w;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		PADDR   <= ~a;
		PWDATA  <= ~d;
	endtask : xfer
	// Mode and masks move only just after an edge.
	task automatic mode(input logic s, input logic i, input logic x);
		@(posedge CLK);
		SPECIAL_MODE <= s;
		I_MASK       <= i;
		X_MASK       <= x;
	endtask : mode
endmodule : itpp_cpu_model
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [7:0] AC = itpp_pkg::ADDR_TEST_CTRL;
	localparam logic [7:0] AW = itpp_pkg::ADDR_TEST_WINDOW;
	localparam logic [7:0] AP = itpp_pkg::ADDR_PROMO_SEL;
	logic         clk = 1'b0;
	logic         reset = 1'b1;
	logic [127:0] int_req = '0;
	logic [127:0] old;
	logic         psel, penable, pwrite, pready, pslverr, spec, im, xm;
	logic [7:0]   paddr, promo_vec;
	logic [31:0]  pwdata, prdata, d;
	logic [127:0] dec_req;
	logic         promo_active;
	logic [31:0]  exp_q[$];
	int           failures = 0;
	int           total_checks = 0;
	int           seed = 31;
	// Free running clock at 125 MHz.
	always #4 clk = ~clk;
	itpp_top u_dut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SPECIAL_MODE(spec), .I_MASK(im),
		.X_MASK(xm), .INT_REQ(int_req), .DEC_REQ(dec_req),
		.PROMO_ACTIVE(promo_active), .PROMO_VEC(promo_vec));
	itpp_cpu_model u_cpu (.CLK(clk), .PREADY(pready), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.SPECIAL_MODE(spec), .I_MASK(im), .X_MASK(xm));
	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	// Reads note their expectation first; the monitor settles it later.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		u_cpu.xfer(1'b0, a, 32'h00000000);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		u_cpu.xfer(1'b1, a, v);
	endtask : wr
	// Let the one-cycle decoder feed catch up before it is looked at.
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	// Every completed read is matched against the oldest note.
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
			check("prdata", prdata, exp_q.pop_front());
		if (psel && penable && pready === 1'b1)
			check("pslverr", {31'h0, pslverr},
				{31'h0, !(paddr == AC || paddr == AW || paddr == AP)});
	end
	// Watchdog: the run needs a few hundred cycles at most.
	initial begin
		#100000;
		failures++;
		summarize();
	end
	// Main sequence.
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rd(AC, 32'h00000000);
		rd(AP, 32'h000000F2);
		rd(8'h00, 32'h00000000);
		int_req <= {$random(seed), $random(seed), $random(seed), $random(seed)};
		wr(AC, 32'h00000013);
		rd(AC, 32'h00000003);
		rd(AW, 32'h00000000);
		u_cpu.mode(1'b1, 1'b1, 1'b0);
		wr(AW, 32'h000000FF);
		rd(AW, {24'h0, int_req[31:24]});
		wr(AC, 32'h000000F3);
		rd(AC, 32'h00000003);
		u_cpu.mode(1'b1, 1'b1, 1'b1);
		old = int_req;
		wr(AC, 32'h00000013);
		@(posedge clk);
		int_req <= ~int_req;
		rd(AW, {24'h0, old[31:24]});
		settle();
		check("dec_req", dec_req[31:0], old[31:0]);
		wr(AW, 32'h000000A5);
		u_cpu.mode(1'b1, 1'b0, 1'b1);
		wr(AW, 32'h0000005A);
		rd(AW, 32'h000000A5);
		settle();
		check("dec_req", {24'h0, dec_req[31:24]}, 32'h000000A5);
		u_cpu.mode(1'b1, 1'b1, 1'b1);
		for (int g = 0; g < 16; g++) begin
			d = $random(seed);
			wr(AC, 32'h10 | g);
			wr(AW, d);
			rd(AW, d & (g == 15 ? 32'h07 : 32'hFF));
		end
		u_cpu.mode(1'b1, 1'b0, 1'b1);
		wr(AP, 32'h00000040);
		rd(AP, 32'h000000F2);
		u_cpu.mode(1'b1, 1'b1, 1'b1);
		wr(AP, 32'h00000041);
		rd(AP, 32'h00000040);
		wr(AC, 32'h00000014);
		wr(AW, 32'h00000001);
		settle();
		check("promo_vec", {24'h0, promo_vec}, 32'h00000040);
		check("promo_active", {31'h0, promo_active}, 32'h00000001);
		wr(AW, 32'h00000000);
		wr(AP, 32'h000000F4);
		settle();
		check("promo_active", {31'h0, promo_active}, {31'h0, d[1]});
		check("promo_vec", {24'h0, promo_vec}, 32'h000000F2);
		summarize();
	end
endmodule : testbench
`default_nettype wire
